/* include/cbc_pkg.sv */
package cbc_pkg;

  // register indices
  localparam logic [7:0] CBC_IDX_OE    = 8'h00;
  localparam logic [7:0] CBC_IDX_PLL   = 8'h01;
  localparam logic [7:0] CBC_IDX_SLEW  = 8'h02;
  localparam logic [7:0] CBC_IDX_FREQ  = 8'h03;
  localparam logic [7:0] CBC_IDX_RSVD  = 8'h04;
  localparam logic [7:0] CBC_IDX_REV   = 8'h05;
  localparam logic [7:0] CBC_IDX_DEV   = 8'h06;
  localparam logic [7:0] CBC_IDX_COUNT = 8'h07;

  // writable-bit masks and fixed levels of reserved bits
  localparam logic [7:0] CBC_OE_MASK    = 8'hDD;
  localparam logic [7:0] CBC_OE_FIXED   = 8'h00;
  localparam logic [7:0] CBC_OE_RESET   = 8'hDD;
  localparam logic [7:0] CBC_PLL_MASK   = 8'h3B;
  localparam logic [7:0] CBC_PLL_FIXED  = 8'h04;
  localparam logic [7:0] CBC_PLL_RESET  = 8'h06;
  localparam logic [7:0] CBC_SLEW_MASK  = 8'hDD;
  localparam logic [7:0] CBC_SLEW_FIXED = 8'h00;
  localparam logic [7:0] CBC_SLEW_RESET = 8'hDD;
  localparam logic [7:0] CBC_FREQ_MASK  = 8'h39;
  localparam logic [7:0] CBC_FREQ_FIXED = 8'h46;
  localparam logic [7:0] CBC_FREQ_RESET = 8'h47;
  localparam logic [7:0] CBC_RSVD_VALUE = 8'hFF;
  localparam logic [7:0] CBC_CNT_MASK   = 8'h1F;
  localparam logic [7:0] CBC_CNT_RESET  = 8'h08;

  // identity bytes: arbitrary values, not those of any real part
  localparam logic [7:0] CBC_REV_ID = 8'h00;
  localparam logic [7:0] CBC_DEV_ID = 8'h00;

  // field positions
  localparam int CBC_PLL_RB_LSB = 6;
  localparam int CBC_PLL_SW_EN  = 5;
  localparam int CBC_PLL_SW_LSB = 3;
  localparam int CBC_AMP_LSB    = 0;
  localparam int CBC_FSEL_EN    = 5;
  localparam int CBC_FSEL_LSB   = 3;
  localparam int CBC_FB_SLEW    = 0;

  // 7-bit target addresses per select pin level
  localparam logic [6:0] CBC_ADDR_LOW  = 7'h6B;
  localparam logic [6:0] CBC_ADDR_HIGH = 7'h6D;

  // smbus line filter depth
  localparam int CBC_FILT_LEN = 3;

endpackage : cbc_pkg

/* include/cbc_reg_if.sv */
`timescale 1ns/1ps
// register access path between the serial engine and the register bank
interface cbc_reg_if;
  logic       wr_en;
  logic [7:0] wr_idx;
  logic [7:0] wr_data;
  logic [7:0] rd_idx;
  logic [7:0] rd_data;
  logic [4:0] rd_count;

  modport engine (output wr_en, output wr_data, output wr_idx, output rd_idx,
                  input rd_data, input rd_count);
  modport bank   (input wr_en, input wr_data, input wr_idx, input rd_idx,
                  output rd_data, output rd_count);
endinterface : cbc_reg_if

/* design/cbc_line_filter.sv */
`timescale 1ns/1ps
// synchroniser plus majority-free glitch filter for one smbus line
module cbc_line_filter
  import cbc_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic arst_n_in,
  input  wire logic line_in,
  output logic      level_out
);
  logic [1:0]              sync_reg;
  logic [CBC_FILT_LEN-1:0] hist_reg;
  logic [CBC_FILT_LEN-1:0] hist_next;
  logic                    level_reg;
  logic                    level_next;

  // level changes only after the line held steady for the whole history
  always_comb begin
    hist_next  = {hist_reg[CBC_FILT_LEN-2:0], sync_reg[1]};
    level_next = level_reg;
    if (&hist_reg) begin
      level_next = 1'b1;
    end else if (~|hist_reg) begin
      level_next = 1'b0;
    end
  end

  // idle bus is high, so reset to one
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sync_reg  <= '1;
      hist_reg  <= '1;
      level_reg <= 1'b1;
    end else begin
      sync_reg  <= {sync_reg[0], line_in};
      hist_reg  <= hist_next;
      level_reg <= level_next;
    end
  end

  assign level_out = level_reg;
endmodule : cbc_line_filter

/* design/cbc_reg_bank.sv */
`timescale 1ns/1ps
// register bank of the clock buffer
module cbc_reg_bank
  import cbc_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic arst_n_in,
  input  wire logic [1:0] mode_latched_in,
  cbc_reg_if.bank         rif,
  output logic [7:0] oe_out,
  output logic [7:0] pll_out,
  output logic [7:0] slew_out,
  output logic [7:0] freq_out
);
  logic [7:0] oe_reg, oe_next, pll_reg, pll_next;
  logic [7:0] slew_reg, slew_next, freq_reg, freq_next, cnt_reg, cnt_next;

  function automatic logic [7:0] merge(input logic [7:0] old_v, input logic [7:0] new_v,
                                       input logic [7:0] mask);
    merge = (old_v & ~mask) | (new_v & mask);
  endfunction : merge

  // only writable bits take the byte; reserved bits keep fixed levels
  always_comb begin
    oe_next   = oe_reg;
    pll_next  = pll_reg;
    slew_next = slew_reg;
    freq_next = freq_reg;
    cnt_next  = cnt_reg;
    if (rif.wr_en) begin
      unique case (rif.wr_idx)
        CBC_IDX_OE:    oe_next   = merge(oe_reg, rif.wr_data, CBC_OE_MASK);
        CBC_IDX_PLL:   pll_next  = merge(pll_reg, rif.wr_data, CBC_PLL_MASK);
        CBC_IDX_SLEW:  slew_next = merge(slew_reg, rif.wr_data, CBC_SLEW_MASK);
        CBC_IDX_FREQ:  freq_next = merge(freq_reg, rif.wr_data, CBC_FREQ_MASK);
        CBC_IDX_COUNT: cnt_next  = merge(cnt_reg, rif.wr_data, CBC_CNT_MASK);
        default:       ;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      oe_reg   <= CBC_OE_RESET;
      pll_reg  <= CBC_PLL_RESET;
      slew_reg <= CBC_SLEW_RESET;
      freq_reg <= CBC_FREQ_RESET;
      cnt_reg  <= CBC_CNT_RESET;
    end else begin
      oe_reg   <= oe_next;
      pll_reg  <= pll_next;
      slew_reg <= slew_next;
      freq_reg <= freq_next;
      cnt_reg  <= cnt_next;
    end
  end

  // read mux; readback bits come from the strap latch, not storage
  always_comb begin
    unique case (rif.rd_idx)
      CBC_IDX_OE:    rif.rd_data = oe_reg | CBC_OE_FIXED;
      CBC_IDX_PLL:   rif.rd_data = {mode_latched_in, pll_reg[5:0]} | CBC_PLL_FIXED;
      CBC_IDX_SLEW:  rif.rd_data = slew_reg | CBC_SLEW_FIXED;
      CBC_IDX_FREQ:  rif.rd_data = freq_reg | CBC_FREQ_FIXED;
      CBC_IDX_RSVD:  rif.rd_data = CBC_RSVD_VALUE;
      CBC_IDX_REV:   rif.rd_data = CBC_REV_ID;
      CBC_IDX_DEV:   rif.rd_data = CBC_DEV_ID;
      CBC_IDX_COUNT: rif.rd_data = cnt_reg;
      default:       rif.rd_data = CBC_RSVD_VALUE;
    endcase
  end

  assign rif.rd_count = cnt_reg[4:0];
  assign oe_out       = oe_reg;
  assign pll_out      = pll_reg;
  assign slew_out     = slew_reg;
  assign freq_out     = freq_reg;
endmodule : cbc_reg_bank

/* design/cbc_smbus_target.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module cbc_smbus_target
  import cbc_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       arst_n_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_out,
  input  wire logic       addr_select_pin_in,
  input  wire logic [1:0] mode_strap_in,
  input  wire logic       oe_n_pin_in,
  output logic [5:0]      diff_clock_enable_out,
  output logic [5:0]      diff_edge_fast_out,
  output logic            feedback_edge_fast_out,
  output logic [1:0]      pll_mode_out,
  output logic [1:0]      amplitude_out,
  output logic            freq_sw_enable_out,
  output logic [1:0]      freq_pick_out
);
  typedef enum {
    CBC_IDLE, CBC_ADDR, CBC_ADDR_ACK, CBC_WBYTE, CBC_WACK,
    CBC_RBYTE, CBC_RACK, CBC_SKIP
  } cbc_state_e;

  ////////////////////////////////////////////////////////////////////////////
  // line conditioning
  logic scl_f, sda_f;

  cbc_line_filter u_scl (.clk_in(clk_in), .arst_n_in(arst_n_in), .line_in(scl_in),
                         .level_out(scl_f));
  cbc_line_filter u_sda (.clk_in(clk_in), .arst_n_in(arst_n_in), .line_in(sda_in),
                         .level_out(sda_f));

  logic scl_d_reg, sda_d_reg;
  logic scl_rise, scl_fall, start_det, stop_det;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_f;
      sda_d_reg <= sda_f;
    end
  end

  // start/stop are sda edges while scl stays high
  assign scl_rise  = scl_f & ~scl_d_reg;
  assign scl_fall  = ~scl_f & scl_d_reg;
  assign start_det = scl_f & scl_d_reg & sda_d_reg & ~sda_f;
  assign stop_det  = scl_f & scl_d_reg & ~sda_d_reg & sda_f;

  ////////////////////////////////////////////////////////////////////////////
  // address and strap latch, caught once after reset release
  logic       latched_reg, latched_next;
  logic [6:0] my_addr_reg, my_addr_next;
  logic [1:0] strap_reg, strap_next;

  always_comb begin
    latched_next = 1'b1;
    my_addr_next = my_addr_reg;
    strap_next   = strap_reg;
    if (!latched_reg) begin
      my_addr_next = addr_select_pin_in ? CBC_ADDR_HIGH : CBC_ADDR_LOW;
      strap_next   = mode_strap_in;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      latched_reg <= 1'b0;
      my_addr_reg <= '0;
      strap_reg   <= '0;
    end else begin
      latched_reg <= latched_next;
      my_addr_reg <= my_addr_next;
      strap_reg   <= strap_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register bank
  cbc_reg_if  rif();
  logic [7:0] oe_v, pll_v, slew_v, freq_v;

  cbc_reg_bank u_bank (
    .clk_in          (clk_in),
    .arst_n_in       (arst_n_in),
    .mode_latched_in (strap_reg),
    .rif             (rif),
    .oe_out          (oe_v),
    .pll_out         (pll_v),
    .slew_out        (slew_v),
    .freq_out        (freq_v)
  );

  ////////////////////////////////////////////////////////////////////////////
  // serial engine
  cbc_state_e state_reg, state_next;
  logic [7:0] shift_reg, shift_next;
  logic [2:0] bit_reg, bit_next;
  logic [1:0] phase_reg, phase_next;   // 0 index, 1 count, 2 data
  logic [7:0] idx_reg, idx_next;
  logic [7:0] left_reg, left_next;
  logic       rd_mode_reg, rd_mode_next;
  logic       first_reg, first_next;   // count byte not yet sent
  logic       drive_reg, drive_next;
  logic       wr_en_reg, wr_en_next;
  logic [7:0] wr_data_reg, wr_data_next;
  logic [7:0] wr_idx_reg, wr_idx_next;
  logic [7:0] tx_byte;

  // byte to send next: count first, then registers
  assign tx_byte = first_reg ? {3'b000, rif.rd_count} : rif.rd_data;
  assign rif.rd_idx = idx_reg;

  always_comb begin
    state_next   = state_reg;
    shift_next   = shift_reg;
    bit_next     = bit_reg;
    phase_next   = phase_reg;
    idx_next     = idx_reg;
    left_next    = left_reg;
    rd_mode_next = rd_mode_reg;
    first_next   = first_reg;
    drive_next   = drive_reg;
    wr_en_next   = 1'b0;
    wr_data_next = wr_data_reg;
    wr_idx_next  = wr_idx_reg;
    if (stop_det) begin
      state_next = CBC_IDLE;
      drive_next = 1'b0;
    end else if (start_det) begin
      // repeated start keeps the index for the read that follows
      state_next = CBC_ADDR;
      bit_next   = 3'd7;
      drive_next = 1'b0;
    end else begin
      unique case (state_reg)
        CBC_IDLE, CBC_SKIP: ;
        CBC_ADDR: if (scl_rise) begin
          shift_next = {shift_reg[6:0], sda_f};
          bit_next   = bit_reg - 3'd1;
          if (bit_reg == 3'd0) begin
            if ({shift_reg[6:0]} == my_addr_reg && latched_reg) begin
              state_next   = CBC_ADDR_ACK;
              rd_mode_next = sda_f;
            end else begin
              state_next = CBC_SKIP;
            end
          end
        end
        CBC_ADDR_ACK: if (scl_fall) begin
          if (!drive_reg) begin
            drive_next = 1'b1;
          end else begin
            bit_next = 3'd7;
            if (rd_mode_reg) begin
              state_next = CBC_RBYTE;
              first_next = 1'b1;
              left_next  = 8'(rif.rd_count);
              shift_next = {3'b000, rif.rd_count};
              drive_next = 1'b1;                        // count byte msb is always zero
            end else begin
              state_next = CBC_WBYTE;
              phase_next = 2'd0;
              drive_next = 1'b0;
            end
          end
        end
        CBC_WBYTE: if (scl_rise) begin
          shift_next = {shift_reg[6:0], sda_f};
          bit_next   = bit_reg - 3'd1;
          if (bit_reg == 3'd0) begin
            state_next = CBC_WACK;
            unique case (phase_reg)
              2'd0: begin
                idx_next   = {shift_reg[6:0], sda_f};
                phase_next = 2'd1;
              end
              2'd1: begin
                left_next  = {shift_reg[6:0], sda_f};
                phase_next = 2'd2;
              end
              default: begin
                if (left_reg != 8'd0) begin
                  wr_en_next   = 1'b1;
                  wr_data_next = {shift_reg[6:0], sda_f};
                  wr_idx_next  = idx_reg;
                  idx_next     = idx_reg + 8'd1;
                  left_next    = left_reg - 8'd1;
                end
              end
            endcase
          end
        end
        CBC_WACK: if (scl_fall) begin
          if (!drive_reg) begin
            drive_next = 1'b1;
          end else begin
            drive_next = 1'b0;
            bit_next   = 3'd7;
            state_next = CBC_WBYTE;
          end
        end
        CBC_RBYTE: if (scl_fall) begin
          if (bit_reg == 3'd0) begin
            state_next = CBC_RACK;
            drive_next = 1'b0;                                  // release for host ack
            if (!first_reg) begin
              idx_next = idx_reg + 8'd1;
            end
            first_next = 1'b0;
          end else begin
            shift_next = {shift_reg[6:0], 1'b0};
            bit_next   = bit_reg - 3'd1;
            drive_next = ~shift_reg[6];
          end
        end
        CBC_RACK: begin
          if (scl_rise && sda_f) begin
            state_next = CBC_SKIP;
          end else if (scl_fall) begin
            // host acked on the rise; loading here keeps the msb from being skipped
            state_next = CBC_RBYTE;
            bit_next   = 3'd7;
            shift_next = tx_byte;
            drive_next = ~tx_byte[7];
          end
        end
        default: state_next = CBC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_reg   <= CBC_IDLE;
      shift_reg   <= '0;
      bit_reg     <= '0;
      phase_reg   <= '0;
      idx_reg     <= '0;
      left_reg    <= '0;
      rd_mode_reg <= 1'b0;
      first_reg   <= 1'b0;
      drive_reg   <= 1'b0;
      wr_en_reg   <= 1'b0;
      wr_data_reg <= '0;
      wr_idx_reg  <= '0;
    end else begin
      state_reg   <= state_next;
      shift_reg   <= shift_next;
      bit_reg     <= bit_next;
      phase_reg   <= phase_next;
      idx_reg     <= idx_next;
      left_reg    <= left_next;
      rd_mode_reg <= rd_mode_next;
      first_reg   <= first_next;
      drive_reg   <= drive_next;
      wr_en_reg   <= wr_en_next;
      wr_data_reg <= wr_data_next;
      wr_idx_reg  <= wr_idx_next;
    end
  end

  assign rif.wr_en   = wr_en_reg;
  assign rif.wr_data = wr_data_reg;
  assign rif.wr_idx  = wr_idx_reg;

  ////////////////////////////////////////////////////////////////////////////
  // output controls, registered so every output comes from a flop
  logic [5:0] en_next, edge_next;
  logic [1:0] mode_next, fsel_next;
  logic [5:0] en_reg, edge_reg;
  logic [1:0] mode_reg, fsel_reg, amp_reg;
  logic       fb_reg, fen_reg;

  always_comb begin
    // a cleared bit wins over the pin; pin low enables
    en_next   = {oe_v[7:6], oe_v[4:2], oe_v[0]} & {6{~oe_n_pin_in}};
    edge_next = {slew_v[7:6], slew_v[4:2], slew_v[0]};
    mode_next = pll_v[CBC_PLL_SW_EN] ? pll_v[CBC_PLL_SW_LSB +: 2]
                                     : strap_reg;
    fsel_next = freq_v[CBC_FSEL_EN] ? freq_v[CBC_FSEL_LSB +: 2]
                                    : 2'b00;
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      en_reg   <= '0;
      edge_reg <= '1;
      mode_reg <= '0;
      fsel_reg <= '0;
      amp_reg  <= '0;
      fb_reg   <= 1'b1;
      fen_reg  <= 1'b0;
    end else begin
      en_reg   <= en_next;
      edge_reg <= edge_next;
      mode_reg <= mode_next;
      fsel_reg <= fsel_next;
      amp_reg  <= pll_v[CBC_AMP_LSB +: 2];
      fb_reg   <= freq_v[CBC_FB_SLEW];
      fen_reg  <= freq_v[CBC_FSEL_EN];
    end
  end

  // open drain: only ever pull low
  assign sda_out                = 1'b0;
  assign sda_oe_out             = drive_reg;
  assign diff_clock_enable_out  = en_reg;
  assign diff_edge_fast_out     = edge_reg;
  assign feedback_edge_fast_out = fb_reg;
  assign pll_mode_out           = mode_reg;
  assign amplitude_out          = amp_reg;
  assign freq_sw_enable_out     = fen_reg;
  assign freq_pick_out          = fsel_reg;
endmodule : cbc_smbus_target

/* tb/cbc_smbus_properties.sv */
`timescale 1ns/1ps
// pin-level checks of the smbus target and its configuration outputs
module cbc_smbus_properties (
  input wire logic       clk_in,
  input wire logic       arst_n_in,
  input wire logic       scl_in,
  input wire logic       sda_out,
  input wire logic       sda_oe_out,
  input wire logic       oe_n_pin_in,
  input wire logic [1:0] mode_strap_in,
  input wire logic [5:0] diff_clock_enable_out,
  input wire logic [5:0] diff_edge_fast_out,
  input wire logic       feedback_edge_fast_out,
  input wire logic [1:0] pll_mode_out,
  input wire logic       freq_sw_enable_out,
  input wire logic [1:0] freq_pick_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  // open drain: the data pin is only ever pulled low
  AST_SDA_OPEN_DRAIN: assert property (sda_out == 1'b0)
    else $error("sda output level not zero");
  // the target may only change sda while scl is low
  AST_DRIVE_RISE_SCL_LOW: assert property ($rose(sda_oe_out) |-> !scl_in)
    else $error("sda pulled while scl high");
  AST_DRIVE_FALL_SCL_LOW: assert property ($fell(sda_oe_out) |-> !scl_in)
    else $error("sda released while scl high");
  AST_SDA_HOLD_SCL_HIGH: assert property (scl_in [*8] |-> $stable(sda_oe_out))
    else $error("sda changed during scl high");
  // a high enable pin keeps every output off, whatever the register holds
  AST_PIN_FORCES_OFF: assert property (oe_n_pin_in [*6] |-> diff_clock_enable_out == 6'h00)
    else $error("output enabled while pin inactive");
  AST_FREQ_GATED: assert property (!freq_sw_enable_out |-> freq_pick_out == 2'b00)
    else $error("frequency pick active while disabled");
  // the strap is latched once, later changes must not reach the mode
  AST_STRAP_LATCHED: assert property ($changed(mode_strap_in) |=> $stable(pll_mode_out))
    else $error("pll mode followed strap pin");
  AST_RESET_FAST: assert property ($rose(arst_n_in) |-> ##4 (diff_edge_fast_out == 6'h3F
    && feedback_edge_fast_out && !freq_sw_enable_out))
    else $error("edge rate or frequency reset level wrong");
  AST_RESET_ENABLED: assert property ($rose(arst_n_in) && !oe_n_pin_in
    |-> ##4 diff_clock_enable_out == 6'h3F)
    else $error("outputs not enabled after reset");

  COV_ACK: cover property ($rose(sda_oe_out));
  COV_FREQ_SW: cover property (freq_sw_enable_out && freq_pick_out == 2'b11);
  COV_MODE_SW: cover property (pll_mode_out == 2'b11);
endmodule : cbc_smbus_properties

bind cbc_smbus_target cbc_smbus_properties u_props (.clk_in(clk_in), .arst_n_in(arst_n_in),
  .scl_in(scl_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out), .oe_n_pin_in(oe_n_pin_in),
  .mode_strap_in(mode_strap_in), .diff_clock_enable_out(diff_clock_enable_out),
  .diff_edge_fast_out(diff_edge_fast_out), .feedback_edge_fast_out(feedback_edge_fast_out),
  .pll_mode_out(pll_mode_out), .freq_sw_enable_out(freq_sw_enable_out),
  .freq_pick_out(freq_pick_out));

/* tb/cbc_host_model.sv */
`timescale 1ns/1ps
// behavioural smbus host; scl idles high, sda released means pulled up
module cbc_host_model (
  input  wire logic clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_pull_out
);
  // half scl period in clocks, well above the target's input filter delay
  localparam int HALF = 12;

  initial begin
    scl_out = 1'b1;
    sda_pull_out = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : hold

  // sda moves mid-low, never with the scl edge, so no false start or stop
  task automatic slot(input logic pull, output logic seen);
    hold(HALF / 2);
    sda_pull_out = pull;
    hold(HALF / 2);
    scl_out = 1'b1;
    hold(HALF / 2);
    seen = sda_in;
    hold(HALF / 2);
    scl_out = 1'b0;
  endtask : slot

  // start or repeated start: sda falls while scl high
  task automatic start_bit();
    hold(HALF / 2);
    sda_pull_out = 1'b0;
    hold(HALF);
    scl_out = 1'b1;
    hold(HALF);
    sda_pull_out = 1'b1;
    hold(HALF);
    scl_out = 1'b0;
  endtask : start_bit

  task automatic stop_bit();
    hold(HALF / 2);
    sda_pull_out = 1'b1;
    hold(HALF);
    scl_out = 1'b1;
    hold(HALF);
    sda_pull_out = 1'b0;
    hold(HALF);
  endtask : stop_bit

  // msb first, ninth slot returns the target's acknowledge
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic seen;
    for (int i = 7; i >= 0; i--) begin
      slot(!b[i], seen);
    end
    slot(1'b0, seen);
    ack = !seen;
  endtask : send_byte

  // every byte acknowledged except the last, which gets a nack
  task automatic recv_byte(input logic last, output logic [7:0] b);
    logic seen;
    for (int i = 7; i >= 0; i--) begin
      slot(1'b0, b[i]);
    end
    slot(!last, seen);
  endtask : recv_byte
endmodule : cbc_host_model

/* tb/tb.sv */
`timescale 1ns/1ps
module tb;
  import cbc_pkg::*;
  logic clk = 1'b0;
  logic arst_n, addr_sel, oe_n, scl, sda_pull, sda_o, sda_oe, sda_line, fb, fen;
  logic [1:0] strap, mode, amp, pick;
  logic [5:0] en, edg;
  int n_errors = 0;
  int n_tests = 0;
  int cycles = 0;

  always #5 clk = ~clk;
  // wired-and of the open drain bus with its pull-up
  assign sda_line = (sda_oe ? sda_o : 1'b1) && !sda_pull;

  cbc_host_model host (.clk_in(clk), .sda_in(sda_line), .scl_out(scl), .sda_pull_out(sda_pull));
  cbc_smbus_target uut (.clk_in(clk), .arst_n_in(arst_n), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_o), .sda_oe_out(sda_oe), .addr_select_pin_in(addr_sel),
    .mode_strap_in(strap), .oe_n_pin_in(oe_n), .diff_clock_enable_out(en),
    .diff_edge_fast_out(edg), .feedback_edge_fast_out(fb), .pll_mode_out(mode),
    .amplitude_out(amp), .freq_sw_enable_out(fen), .freq_pick_out(pick));

  task automatic end_of_test();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  // a hung bus ends the run as a failure instead of stalling
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      end_of_test();
    end
  end

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic port_chk(input logic [5:0] e, input logic [5:0] s, input logic f,
                          input logic [1:0] m, input logic [1:0] a, input logic fe,
                          input logic [1:0] p);
    check("enables", {2'b00, e}, {2'b00, en});
    check("edge rates", {2'b00, s}, {2'b00, edg});
    check("feedback edge", {7'h00, f}, {7'h00, fb});
    check("pll mode", {6'h00, m}, {6'h00, mode});
    check("amplitude", {6'h00, a}, {6'h00, amp});
    check("freq enable", {7'h00, fe}, {7'h00, fen});
    check("freq pick", {6'h00, p}, {6'h00, pick});
  endtask : port_chk

  // a target that is not addressed must not acknowledge its address; the rest of the frame is then not sent
  task automatic blk_write(input logic [6:0] adr, input logic [7:0] idx, input logic [7:0] d[$]);
    logic ack;
    host.start_bit();
    host.send_byte({adr, 1'b0}, ack);
    check("addr ack", {7'h00, adr == CBC_ADDR_HIGH}, {7'h00, ack});
    if (ack === 1'b1) begin
      host.send_byte(idx, ack);
      check("index ack", 8'h01, {7'h00, ack});
      host.send_byte(8'(d.size()), ack);
      check("count ack", 8'h01, {7'h00, ack});
      foreach (d[i]) begin
        host.send_byte(d[i], ack);
        check("data ack", 8'h01, {7'h00, ack});
      end
    end
    host.stop_bit();
  endtask : blk_write

  // exp holds the count byte first, then the register bytes
  task automatic blk_read(input logic [7:0] idx, input logic [7:0] exp[$]);
    logic ack;
    logic [7:0] b;
    host.start_bit();
    host.send_byte({CBC_ADDR_HIGH, 1'b0}, ack);
    host.send_byte(idx, ack);
    host.start_bit();
    host.send_byte({CBC_ADDR_HIGH, 1'b1}, ack);
    check("read addr ack", 8'h01, {7'h00, ack});
    foreach (exp[i]) begin
      host.recv_byte(i == exp.size() - 1, b);
      check("read byte", exp[i], b);
    end
    host.stop_bit();
  endtask : blk_read

  ////////////////////////////////////////////////////////////
  initial begin
    arst_n = 1'b0;
    addr_sel = 1'b1;
    strap = 2'b10;
    oe_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 arst_n = 1'b1;
    repeat (10) @(posedge clk);
    #1;
    addr_sel = 1'b0;
    strap = 2'b01;
    port_chk(6'h3F, 6'h3F, 1'b1, 2'b10, 2'b10, 1'b0, 2'b00);
    blk_read(CBC_IDX_OE, '{8'h08, 8'hDD, 8'h86, 8'hDD, 8'h47, 8'hFF, CBC_REV_ID, CBC_DEV_ID,
                           8'h08});
    blk_write(CBC_ADDR_HIGH, CBC_IDX_OE, '{8'h22, 8'hFF, 8'h00, 8'hFF});
    port_chk(6'h00, 6'h00, 1'b1, 2'b11, 2'b11, 1'b1, 2'b11);
    blk_write(CBC_ADDR_HIGH, CBC_IDX_COUNT, '{8'hE4});
    blk_read(CBC_IDX_OE, '{8'h04, 8'h00, 8'hBF, 8'h00, 8'h7F});
    blk_write(CBC_ADDR_HIGH, CBC_IDX_OE, '{8'hDD, 8'h18, 8'hDD, 8'h18});
    port_chk(6'h3F, 6'h3F, 1'b0, 2'b10, 2'b00, 1'b0, 2'b00);
    blk_read(CBC_IDX_PLL, '{8'h04, 8'h9C, 8'hDD, 8'h5E, 8'hFF});
    blk_write(CBC_ADDR_LOW, CBC_IDX_OE, '{8'h00});
    port_chk(6'h3F, 6'h3F, 1'b0, 2'b10, 2'b00, 1'b0, 2'b00);
    oe_n = 1'b1;
    repeat (10) @(posedge clk);
    #1;
    check("enables pin off", 8'h00, {2'b00, en});
    oe_n = 1'b0;
    repeat (10) @(posedge clk);
    #1;
    check("enables pin on", 8'h3F, {2'b00, en});
    end_of_test();
  end
endmodule : tb
